// *** hdl/bfps_consts.svh ***
// timing constants and field widths for the buck supervisor
`ifndef BFPS_CONSTS_SVH
`define BFPS_CONSTS_SVH

`define BFPS_CLK_MHZ         125
`define BFPS_PG_ON_US        1000
`define BFPS_PG_OFF_NS       2000
`define BFPS_UV_DELAY_US     1000
`define BFPS_UV_BLANK_US     1200
`define BFPS_SS_RAMP_US      750
`define BFPS_PG_ON_CYC       (18'(`BFPS_PG_ON_US * `BFPS_CLK_MHZ))
`define BFPS_PG_OFF_CYC      (18'((`BFPS_PG_OFF_NS * `BFPS_CLK_MHZ) / 1000))
`define BFPS_UV_DELAY_CYC    (18'(`BFPS_UV_DELAY_US * `BFPS_CLK_MHZ))
`define BFPS_UV_BLANK_CYC    (18'(`BFPS_UV_BLANK_US * `BFPS_CLK_MHZ))
`define BFPS_SS_RAMP_CYC     (18'(`BFPS_SS_RAMP_US * `BFPS_CLK_MHZ))
`define BFPS_CNT_W           18
`define BFPS_CNT_ZERO        18'h0_0000
`define BFPS_CNT_ONE         18'h0_0001
`define BFPS_REF_W           10
`define BFPS_REF_ZERO        10'h000
`define BFPS_REF_FULL        10'h3_FF

`endif

// *** hdl/bfps_pkg.sv ***
// types for the buck supervisor
package bfps_pkg;
    typedef enum logic [1:0] {
        BFPS_OFF,
        BFPS_SOFTSTART,
        BFPS_RUN,
        BFPS_LATCHED
    } bfps_state_e;

    typedef enum logic [1:0] {
        BFPS_PG_LOW,
        BFPS_PG_QUAL,
        BFPS_PG_HIGH,
        BFPS_PG_DROP
    } bfps_pg_e;
endpackage

// *** hdl/bfps_delay.sv ***
// delay counter: output rises after input held high for a count
`timescale 1ns/100ps
`include "bfps_consts.svh"
module bfps_delay #(
    parameter logic [`BFPS_CNT_W-1:0] DELAY_CYC = `BFPS_CNT_ONE
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // control
    input  wire logic                   clear,
    input  wire logic                   run,
    // result
    output logic                        expired
);
    typedef struct packed {
        logic [`BFPS_CNT_W-1:0] count;
        logic                   done;
    } bfps_delay_s;

    bfps_delay_s state;
    bfps_delay_s next_state;

    always_comb
    begin
        next_state = state;
        if (clear || !run)
        begin
            next_state.count = `BFPS_CNT_ZERO;
            next_state.done  = 1'b0;
        end
        else if (!state.done)
        begin
            if (state.count >= DELAY_CYC - `BFPS_CNT_ONE)
                next_state.done = 1'b1;
            else
                next_state.count = state.count + `BFPS_CNT_ONE;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign expired = state.done;
endmodule

// *** hdl/bfps_softstart.sv ***
// reference ramp generator for soft-start
`timescale 1ns/100ps
`include "bfps_consts.svh"
module bfps_softstart #(
    parameter logic [`BFPS_CNT_W-1:0] RAMP_CYC = `BFPS_SS_RAMP_CYC
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // control
    input  wire logic                   start,
    input  wire logic                   abort,
    // status
    output logic [`BFPS_REF_W-1:0]      ref_level,
    output logic                        done
);
    typedef struct packed {
        logic [`BFPS_CNT_W-1:0] count;
        logic [`BFPS_REF_W-1:0] level;
        logic                   active;
        logic                   done;
    } bfps_ss_s;

    bfps_ss_s state;
    bfps_ss_s next_state;
    logic [`BFPS_CNT_W+`BFPS_REF_W-1:0] scaled;

    always_comb
    begin
        next_state = state;
        scaled = '0;
        if (abort)
        begin
            next_state = '0;
        end
        else if (start)
        begin
            next_state.count  = `BFPS_CNT_ZERO;
            next_state.level  = `BFPS_REF_ZERO;
            next_state.active = 1'b1;
            next_state.done   = 1'b0;
        end
        else if (state.active)
        begin
            if (state.count >= RAMP_CYC - `BFPS_CNT_ONE)
            begin
                next_state.active = 1'b0;
                next_state.done   = 1'b1;
                next_state.level  = `BFPS_REF_FULL;
            end
            else
            begin
                next_state.count = state.count + `BFPS_CNT_ONE;
                scaled = {`BFPS_REF_W'(0), state.count} * {`BFPS_CNT_W'(0), `BFPS_REF_FULL};
                next_state.level = `BFPS_REF_W'(scaled / {`BFPS_REF_W'(0), RAMP_CYC});
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= '0;
        else
            state <= next_state;
    end

    assign ref_level = state.level;
    assign done      = state.done;
endmodule

// *** hdl/bfps_supervisor.sv ***
// protection and power-good supervisor of a step-down controller
`timescale 1ns/100ps
`include "bfps_consts.svh"
// Overview of operation
// [RULE1] power_ok_output held low until soft-start ramp completes
// [RULE2] inside +10%/-5% window for 1 ms, release power_ok_output high
// [RULE3] outside +15%/-10% band for 2 us, pull power_ok_output low
// [RULE4] power_ok_output is open drain; board pull-up makes the high level
// [RULE5] current checked in off state; high-side turn-on held while over trip
// [RULE6] feedback above 120% latches fault: high gate off, low gate on
// [RULE7] feedback below 70% for 1 ms latches both gate drives off
// [RULE8] undervoltage detection ignored until 1.2 ms after enable rises
// [RULE9] bias lockout stops switching, resumes when bias recovers
// [RULE10] over-temperature stops switching, releases when flag clears
// [RULE11] enable rise ramps reference over 750 us, then signals done
// [RULE12] enable low: both gates off, switch_node discharge on
// [RULE13] feedback recovering above 70% clears undervoltage counter
// [RULE14] latched faults persist until enable low or bias cycled
module bfps_supervisor #(
    parameter logic [`BFPS_CNT_W-1:0] PG_ON_CYC    = `BFPS_PG_ON_CYC,
    parameter logic [`BFPS_CNT_W-1:0] PG_OFF_CYC   = `BFPS_PG_OFF_CYC,
    parameter logic [`BFPS_CNT_W-1:0] UV_DELAY_CYC = `BFPS_UV_DELAY_CYC,
    parameter logic [`BFPS_CNT_W-1:0] UV_BLANK_CYC = `BFPS_UV_BLANK_CYC,
    parameter logic [`BFPS_CNT_W-1:0] SS_RAMP_CYC  = `BFPS_SS_RAMP_CYC
) (
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    // enable and bias
    input  wire logic                   enable,
    input  wire logic                   bias_lockout,
    input  wire logic                   over_temp,
    // feedback comparators
    input  wire logic                   fb_in_window,
    input  wire logic                   fb_out_band,
    input  wire logic                   fb_over_120,
    input  wire logic                   fb_under_70,
    // modulator
    input  wire logic                   pwm_set,
    input  wire logic                   on_time_done,
    input  wire logic                   valley_current_limit,
    // gate drive and discharge
    output logic                        high_gate_drive,
    output logic                        low_gate_drive,
    output logic                        switch_node_discharge,
    // power good open drain
    output logic                        power_ok_output_o,
    output logic                        power_ok_output_oe,
    // status
    output logic [`BFPS_REF_W-1:0]      ref_level,
    output logic                        soft_start_done,
    output logic                        overvoltage_latch,
    output logic                        undervoltage_latch
);
    typedef struct packed {
        bfps_pkg::bfps_state_e mode;
        bfps_pkg::bfps_pg_e    pg;
        logic                  enable_q;
        logic                  bias_q;
        logic                  ov;
        logic                  uv;
        logic                  high_on;
        logic                  high_gate;
        logic                  low_gate;
        logic                  discharge;
        logic                  pg_release;
    } bfps_sup_s;

    bfps_sup_s state;
    bfps_sup_s next_state;

    logic enable_rise;
    logic bias_fall;
    logic ss_done;
    logic pg_on_exp;
    logic pg_off_exp;
    logic uv_blank_exp;
    logic uv_delay_exp;
    logic switch_ok;
    logic in_run;

    assign enable_rise = enable && !state.enable_q;
    assign bias_fall   = bias_lockout && !state.bias_q;
    assign in_run      = (state.mode == bfps_pkg::BFPS_RUN) ||
                         (state.mode == bfps_pkg::BFPS_SOFTSTART);
    assign switch_ok   = !bias_lockout && !over_temp; // [RULE9] [RULE10]

    // reference ramp
    bfps_softstart #(
        .RAMP_CYC  (SS_RAMP_CYC)
    ) u_softstart (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .start     (enable_rise),
        .abort     (!enable),
        .ref_level (ref_level),
        .done      (ss_done)
    ); // [RULE11]

    // power-good qualify and drop delays
    bfps_delay #(
        .DELAY_CYC (PG_ON_CYC)
    ) u_pg_on (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clear     (!ss_done),
        .run       (fb_in_window && !fb_out_band),
        .expired   (pg_on_exp)
    ); // [RULE2]

    bfps_delay #(
        .DELAY_CYC (PG_OFF_CYC)
    ) u_pg_off (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clear     (!ss_done),
        .run       (fb_out_band),
        .expired   (pg_off_exp)
    ); // [RULE3]

    // undervoltage blanking after enable
    bfps_delay #(
        .DELAY_CYC (UV_BLANK_CYC)
    ) u_uv_blank (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clear     (1'b0),
        .run       (enable),
        .expired   (uv_blank_exp)
    ); // [RULE8]

    // undervoltage delay, cleared when feedback recovers
    bfps_delay #(
        .DELAY_CYC (UV_DELAY_CYC)
    ) u_uv_delay (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .clear     (!uv_blank_exp),
        .run       (fb_under_70), // [RULE13]
        .expired   (uv_delay_exp)
    ); // [RULE7]

    always_comb
    begin
        next_state          = state;
        next_state.enable_q = enable;
        next_state.bias_q   = bias_lockout;

        // fault latches
        if (!enable || bias_fall)
        begin
            next_state.ov = 1'b0; // [RULE14]
            next_state.uv = 1'b0; // [RULE14]
        end
        else
        begin
            if (fb_over_120 && in_run)
                next_state.ov = 1'b1; // [RULE6]
            if (uv_delay_exp && in_run)
                next_state.uv = 1'b1; // [RULE7]
        end

        // sequencing
        unique case (state.mode)
            bfps_pkg::BFPS_OFF:
            begin
                if (enable_rise)
                    next_state.mode = bfps_pkg::BFPS_SOFTSTART;
            end
            bfps_pkg::BFPS_SOFTSTART:
            begin
                if (ss_done)
                    next_state.mode = bfps_pkg::BFPS_RUN;
            end
            bfps_pkg::BFPS_RUN:
            begin
            end
            bfps_pkg::BFPS_LATCHED:
            begin
            end
        endcase
        if (next_state.ov || next_state.uv)
            next_state.mode = bfps_pkg::BFPS_LATCHED;
        if (!enable)
            next_state.mode = bfps_pkg::BFPS_OFF; // [RULE12]

        // switching cycle: on until on-time ends, off until set and current low
        if (!state.high_on)
        begin
            if (pwm_set && !valley_current_limit)
                next_state.high_on = 1'b1; // [RULE5]
        end
        else if (on_time_done)
        begin
            next_state.high_on = 1'b0;
        end

        // gate outputs
        next_state.discharge = 1'b0;
        if (next_state.mode == bfps_pkg::BFPS_OFF)
        begin
            next_state.high_on   = 1'b0;
            next_state.high_gate = 1'b0;
            next_state.low_gate  = 1'b0;
            next_state.discharge = 1'b1; // [RULE12]
        end
        else if (next_state.ov)
        begin
            next_state.high_on   = 1'b0;
            next_state.high_gate = 1'b0;
            next_state.low_gate  = 1'b1; // [RULE6]
        end
        else if (next_state.uv || !switch_ok)
        begin
            next_state.high_on   = 1'b0;
            next_state.high_gate = 1'b0;
            next_state.low_gate  = 1'b0; // [RULE7] [RULE9] [RULE10]
        end
        else
        begin
            next_state.high_gate = next_state.high_on;
            next_state.low_gate  = !next_state.high_on;
        end

        // power-good state
        unique case (state.pg)
            bfps_pkg::BFPS_PG_LOW:
            begin
                if (ss_done)
                    next_state.pg = bfps_pkg::BFPS_PG_QUAL;
            end
            bfps_pkg::BFPS_PG_QUAL:
            begin
                if (pg_on_exp)
                    next_state.pg = bfps_pkg::BFPS_PG_HIGH; // [RULE2]
            end
            bfps_pkg::BFPS_PG_HIGH:
            begin
                if (pg_off_exp)
                    next_state.pg = bfps_pkg::BFPS_PG_DROP; // [RULE3]
            end
            bfps_pkg::BFPS_PG_DROP:
            begin
                if (!fb_out_band)
                    next_state.pg = bfps_pkg::BFPS_PG_QUAL;
            end
        endcase
        if (!ss_done || next_state.mode != bfps_pkg::BFPS_RUN)
            next_state.pg = bfps_pkg::BFPS_PG_LOW; // [RULE1]
        next_state.pg_release = (next_state.pg == bfps_pkg::BFPS_PG_HIGH);
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state           <= '0;
            state.mode      <= bfps_pkg::BFPS_OFF;
            state.pg        <= bfps_pkg::BFPS_PG_LOW;
            state.discharge <= 1'b1;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign high_gate_drive       = state.high_gate;
    assign low_gate_drive        = state.low_gate;
    assign switch_node_discharge = state.discharge;
    assign power_ok_output_o     = 1'b0; // [RULE4]
    assign power_ok_output_oe    = !state.pg_release; // [RULE4]
    assign soft_start_done       = ss_done;
    assign overvoltage_latch     = state.ov;
    assign undervoltage_latch    = state.uv;
endmodule

// *** tb/bfps_power_stage.sv ***
// model of the external switches, power good pull-up and current sense
`timescale 1ns/100ps
module bfps_power_stage (
    // gate drive
    input  wire logic high_gate_drive,
    // power good open drain
    input  wire logic pg_data,
    input  wire logic pg_pull,
    output logic      pg_pin,
    // current sense
    input  wire logic overload,
    output logic      valley_trip
);
    // board pull-up makes the high level
    assign pg_pin = pg_pull ? pg_data : 1'h1;
    // current seen across the low switch only while the high switch is off
    assign valley_trip = overload && !high_gate_drive;
endmodule

// *** tb/bfps_supervisor_checker.sv ***
// port assertions for the buck supervisor
`timescale 1ns/100ps
`include "bfps_consts.svh"
module bfps_supervisor_checker #(
    parameter logic [`BFPS_CNT_W-1:0] PG_ON_CYC    = `BFPS_PG_ON_CYC,
    parameter logic [`BFPS_CNT_W-1:0] PG_OFF_CYC   = `BFPS_PG_OFF_CYC,
    parameter logic [`BFPS_CNT_W-1:0] UV_DELAY_CYC = `BFPS_UV_DELAY_CYC,
    parameter logic [`BFPS_CNT_W-1:0] UV_BLANK_CYC = `BFPS_UV_BLANK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // inputs
    input wire logic enable,
    input wire logic bias_lockout,
    input wire logic over_temp,
    input wire logic fb_in_window,
    input wire logic fb_out_band,
    input wire logic fb_under_70,
    input wire logic valley_current_limit,
    // outputs
    input wire logic high_gate_drive,
    input wire logic low_gate_drive,
    input wire logic switch_node_discharge,
    input wire logic power_ok_output_o,
    input wire logic power_ok_output_oe,
    input wire logic soft_start_done,
    input wire logic overvoltage_latch,
    input wire logic undervoltage_latch
);
    logic [`BFPS_CNT_W-1:0] en_cnt;
    logic [`BFPS_CNT_W-1:0] win_cnt;
    logic [`BFPS_CNT_W-1:0] uv_cnt;
    logic [`BFPS_CNT_W-1:0] out_cnt;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    // run lengths of enable, window, undervoltage and out-of-band
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            en_cnt  <= '0;
            win_cnt <= '0;
            uv_cnt  <= '0;
            out_cnt <= '0;
        end
        else
        begin
            en_cnt  <= enable ? en_cnt + `BFPS_CNT_ONE : '0;
            win_cnt <= (fb_in_window && soft_start_done) ? win_cnt + `BFPS_CNT_ONE : '0;
            uv_cnt  <= (fb_under_70 && enable) ? uv_cnt + `BFPS_CNT_ONE : '0;
            out_cnt <= (fb_out_band && soft_start_done) ? out_cnt + `BFPS_CNT_ONE : '0;
        end
    end
    property p_pg_hold;
        !soft_start_done && !$past(soft_start_done) |-> power_ok_output_oe;
    endproperty
    a_pg_hold: assert property (p_pg_hold) else $error("power good early");
    property p_pg_qual;
        $fell(power_ok_output_oe) |-> win_cnt >= PG_ON_CYC;
    endproperty
    a_pg_qual: assert property (p_pg_qual) else $error("power good too soon");
    property p_pg_drop;
        out_cnt > PG_OFF_CYC |-> power_ok_output_oe;
    endproperty
    a_pg_drop: assert property (p_pg_drop) else $error("power good not dropped");
    property p_drain;
        power_ok_output_oe |-> !power_ok_output_o;
    endproperty
    a_drain: assert property (p_drain) else $error("power good driven high");
    property p_valley;
        valley_current_limit && !high_gate_drive |=> !high_gate_drive;
    endproperty
    a_valley: assert property (p_valley) else $error("high gate over trip");
    property p_ov_gates;
        overvoltage_latch && enable && !bias_lockout && !over_temp
            |=> !high_gate_drive && low_gate_drive;
    endproperty
    a_ov_gates: assert property (p_ov_gates) else $error("overvoltage gates");
    property p_uv_latch;
        $rose(undervoltage_latch) |-> uv_cnt >= UV_DELAY_CYC && en_cnt >= UV_BLANK_CYC;
    endproperty
    a_uv_latch: assert property (p_uv_latch) else $error("undervoltage early");
    property p_stop;
        bias_lockout || over_temp |=> !high_gate_drive && !low_gate_drive;
    endproperty
    a_stop: assert property (p_stop) else $error("switching while stopped");
    property p_en_low;
        !enable |=> !high_gate_drive && !low_gate_drive && switch_node_discharge
            && !overvoltage_latch && !undervoltage_latch;
    endproperty
    a_en_low: assert property (p_en_low) else $error("enable low outputs");
endmodule

bind bfps_supervisor bfps_supervisor_checker #(.PG_ON_CYC(PG_ON_CYC), .PG_OFF_CYC(PG_OFF_CYC),
    .UV_DELAY_CYC(UV_DELAY_CYC), .UV_BLANK_CYC(UV_BLANK_CYC)) u_bfps_supervisor_checker (
    .sys_clk(sys_clk), .rst_n(rst_n), .enable(enable), .bias_lockout(bias_lockout),
    .over_temp(over_temp), .fb_in_window(fb_in_window), .fb_out_band(fb_out_band),
    .fb_under_70(fb_under_70), .valley_current_limit(valley_current_limit),
    .high_gate_drive(high_gate_drive), .low_gate_drive(low_gate_drive),
    .switch_node_discharge(switch_node_discharge), .power_ok_output_o(power_ok_output_o),
    .power_ok_output_oe(power_ok_output_oe), .soft_start_done(soft_start_done),
    .overvoltage_latch(overvoltage_latch), .undervoltage_latch(undervoltage_latch));

// *** tb/bfps_supervisor_bench.sv ***
// self-checking bench for the buck supervisor
`timescale 1ns/100ps
`include "bfps_consts.svh"
module bfps_supervisor_bench;
    typedef struct packed {
        logic       win;
        logic       band;
        logic [7:0] wait_cyc;
        logic       pin;
    } bfps_row_s;
    bfps_row_s rows [7] = '{'{1'h1, 1'h0, 8'h0A, 1'h0}, '{1'h1, 1'h0, 8'h0E, 1'h1},
        '{1'h0, 1'h0, 8'h14, 1'h1}, '{1'h0, 1'h1, 8'h03, 1'h1}, '{1'h0, 1'h1, 8'h05, 1'h0},
        '{1'h1, 1'h0, 8'h0C, 1'h0}, '{1'h1, 1'h0, 8'h0C, 1'h1}};
    logic sys_clk = 1'h0, rst_n = 1'h0, enable = 1'h0, bias_lockout = 1'h0, over_temp = 1'h0;
    logic fb_in_window = 1'h0, fb_out_band = 1'h0, fb_over_120 = 1'h0, fb_under_70 = 1'h0;
    logic pwm_set = 1'h0, on_time_done = 1'h0, overload = 1'h0, valley, pin;
    logic hg, lg, dis, pg_o, pg_oe, ss_done, ov, uv;
    logic [`BFPS_REF_W-1:0] ref_level;
    int   n_fail = 0, comparisons = 0, cyc = 0, n;

    always #4 sys_clk = ~sys_clk;

    bfps_supervisor #(.PG_ON_CYC(18'h0_0014), .PG_OFF_CYC(18'h0_0005),
        .UV_DELAY_CYC(18'h0_0014), .UV_BLANK_CYC(18'h0_001E), .SS_RAMP_CYC(18'h0_0028))
    u_bfps_supervisor (.sys_clk(sys_clk), .rst_n(rst_n), .enable(enable),
        .bias_lockout(bias_lockout), .over_temp(over_temp), .fb_in_window(fb_in_window),
        .fb_out_band(fb_out_band), .fb_over_120(fb_over_120), .fb_under_70(fb_under_70),
        .pwm_set(pwm_set), .on_time_done(on_time_done), .valley_current_limit(valley),
        .high_gate_drive(hg), .low_gate_drive(lg), .switch_node_discharge(dis),
        .power_ok_output_o(pg_o), .power_ok_output_oe(pg_oe), .ref_level(ref_level),
        .soft_start_done(ss_done), .overvoltage_latch(ov), .undervoltage_latch(uv));

    bfps_power_stage u_bfps_power_stage (.high_gate_drive(hg), .pg_data(pg_o),
        .pg_pull(pg_oe), .pg_pin(pin), .overload(overload), .valley_trip(valley));

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input logic seen, input logic exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %b want %b", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            end_of_test;
        end
    end

    initial
    begin
        tick(2);
        check(dis, 1'h1);
        check(pin, 1'h0);
        @(posedge sys_clk) rst_n <= 1'h1;
        @(posedge sys_clk) enable <= 1'h1;
        fb_in_window <= 1'h1;
        n = 0;
        while (ss_done !== 1'h1 && n < 200)
        begin
            tick(1);
            n++;
            if (n == 35)
                check(pin, 1'h0);
        end
        check(n >= 39 && n <= 43, 1'h1);
        check(ref_level === `BFPS_REF_FULL, 1'h1);
        foreach (rows[i])
        begin
            @(posedge sys_clk) fb_in_window <= rows[i].win;
            fb_out_band <= rows[i].band;
            tick(int'(rows[i].wait_cyc));
            check(pin, rows[i].pin);
        end
        @(posedge sys_clk) pwm_set <= 1'h1;
        overload <= 1'h1;
        tick(4);
        check(hg, 1'h0);
        @(posedge sys_clk) overload <= 1'h0;
        tick(4);
        check(hg, 1'h1);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk) bias_lockout <= (i == 0);
            over_temp <= (i == 1);
            tick(3);
            check(hg | lg, 1'h0);
            @(posedge sys_clk) bias_lockout <= 1'h0;
            over_temp <= 1'h0;
            tick(4);
            check(hg, 1'h1);
        end
        @(posedge sys_clk) fb_over_120 <= 1'h1;
        @(posedge sys_clk) fb_over_120 <= 1'h0;
        tick(3);
        check(ov & lg & !hg, 1'h1);
        tick(10);
        check(ov, 1'h1);
        @(posedge sys_clk) enable <= 1'h0;
        tick(2);
        check(ov | hg | lg | !dis, 1'h0);
        @(posedge sys_clk) enable <= 1'h1;
        fb_under_70 <= 1'h1;
        tick(45);
        check(uv, 1'h0);
        tick(10);
        check(uv & !hg & !lg, 1'h1);
        @(posedge sys_clk) enable <= 1'h0;
        fb_under_70 <= 1'h0;
        tick(2);
        @(posedge sys_clk) enable <= 1'h1;
        tick(35);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge sys_clk) fb_under_70 <= 1'h0;
            @(posedge sys_clk) fb_under_70 <= 1'h1;
            tick(15);
        end
        check(uv, 1'h0);
        tick(10);
        check(uv, 1'h1);
        end_of_test;
    end
endmodule
